// >>> hdl/srwb_core.sv
// srwb_core: executes state register writes and the store barrier for the integer unit.
// assumes in-order instruction completion strobes from the pipeline, store issue and
// completion strobes from the store path, and an Avalon-MM master on the same clock.
`timescale 1ns/100ps

module srwb_core import srwb_pkg::*; #(
	parameter int WINDOW_COUNT = 8,
	parameter int WR_DELAY = SRWB_WR_DELAY,
	parameter bit PSO_SUPPORTED = 1'b1,
	parameter int ST_CNT_W = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// instruction completion from the pipeline
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] src1_val_i,
	input wire logic [31:0] src2_val_i,
	// trap logic
	input wire logic trap_take_i,
	output logic trap_valid_o,
	output srwb_trap_type trap_code_o,
	// committed state and forwarded interrupt controls
	output logic [31:0] psr_o,
	output logic [31:0] wim_o,
	output logic [31:0] tbr_o,
	output logic [31:0] y_o,
	output logic int_et_o,
	output logic [3:0] int_pil_o,
	// store path
	input wire logic st_issue_i,
	input wire logic st_done_i,
	output logic st_hold_o,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	localparam logic [1:0] DELAY_LOAD = 2'(WR_DELAY);
	localparam logic [4:0] CWP_LIMIT = 5'(WINDOW_COUNT);
	localparam logic [31:0] WIM_WR_MASK = 32'((64'h1 << WINDOW_COUNT) - 64'h1);

	srwb_instr_type ins;
	srwb_tgt_type tgt;
	logic is_wr;
	logic is_priv;
	logic priv_viol;
	logic cwp_bad;
	logic accept;
	logic barrier;
	logic [31:0] operand;
	logic [31:0] wval;
	logic [31:0] wmask;
	logic commit_now;
	srwb_pend_type pend_r;
	logic pend_valid_r;
	logic [1:0] pend_cnt_r;
	logic [31:0] psr_r;
	logic [31:0] wim_r;
	logic [31:0] tbr_r;
	logic [31:0] y_r;
	logic [31:0] asr_r [16];
	logic int_et_r;
	logic [3:0] int_pil_r;
	logic trap_valid_r;
	srwb_trap_type trap_code_r;
	logic pso_en_r;
	logic [ST_CNT_W-1:0] st_out_r;
	logic [ST_CNT_W-1:0] st_out_nxt;
	logic st_hold_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic req;

	// instruction decode and write value
	always_comb begin
		ins = srwb_instr_type'(instr_i);
		is_wr = 1'b0;
		tgt = SRWB_TGT_NONE;
		is_priv = 1'b0;
		if (ins.op == SRWB_OP_ARITH) begin
			case (ins.op3)
				SRWB_OP3_WR_AUX: begin
					is_wr = 1'b1;
					if (ins.rd == 5'h00) begin
						tgt = SRWB_TGT_Y;
					end else if (ins.rd >= SRWB_ASR_IMPL_FIRST) begin
						tgt = SRWB_TGT_ASR;
						is_priv = (ins.rd >= SRWB_ASR_PRIV_FIRST);
					end else begin
						tgt = SRWB_TGT_NONE; // reserved numbers do nothing
					end
				end
				SRWB_OP3_WR_PSR: begin
					is_wr = 1'b1;
					tgt = SRWB_TGT_PSR;
					is_priv = 1'b1;
				end
				SRWB_OP3_WR_WIM: begin
					is_wr = 1'b1;
					tgt = SRWB_TGT_WIM;
					is_priv = 1'b1;
				end
				SRWB_OP3_WR_TBR: begin
					is_wr = 1'b1;
					tgt = SRWB_TGT_TBR;
					is_priv = 1'b1;
				end
				default: begin
					is_wr = 1'b0;
				end
			endcase
		end
		// exclusive-or of first source with register or sign-extended immediate
		operand = ins.imm_sel ? {{19{ins.signed_imm_field[12]}}, ins.signed_imm_field}
			: src2_val_i;
		wval = src1_val_i ^ operand;
		case (tgt)
			SRWB_TGT_PSR: wmask = SRWB_PSR_WR_MASK;
			SRWB_TGT_WIM: wmask = WIM_WR_MASK;
			SRWB_TGT_TBR: wmask = SRWB_TBR_WR_MASK;
			default: wmask = 32'hffff_ffff;
		endcase
		priv_viol = instr_valid_i && is_wr && is_priv && !psr_r[SRWB_PSR_S_BIT];
		cwp_bad = (tgt == SRWB_TGT_PSR)
			&& (wval[SRWB_PSR_CWP_LSB +: 5] >= CWP_LIMIT);
		accept = instr_valid_i && is_wr && (tgt != SRWB_TGT_NONE) && !priv_viol && !cwp_bad;
		barrier = instr_valid_i && (ins.op == SRWB_OP_ARITH) && (ins.op3 == SRWB_OP3_RD_ANC)
			&& (ins.rs1 == SRWB_BARRIER_SRC1) && (ins.rd == 5'h00);
	end

	// a pending write commits after the chosen number of following instructions,
	// when a trap is taken, or when a newer write displaces it
	assign commit_now = pend_valid_r && ((pend_cnt_r == 2'h0)
		|| (instr_valid_i && !accept && (pend_cnt_r == 2'h1))
		|| trap_take_i
		|| accept);

	// pending write slot
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_valid_r <= 1'b0;
			pend_cnt_r <= 2'h0;
			pend_r <= '{tgt: SRWB_TGT_NONE, asr_idx: 4'h0, value: 32'h0000_0000};
		end else if (accept) begin
			pend_valid_r <= 1'b1;
			pend_cnt_r <= DELAY_LOAD;
			pend_r <= '{tgt: tgt, asr_idx: ins.rd[3:0], value: wval & wmask};
		end else if (commit_now) begin
			pend_valid_r <= 1'b0;
		end else if (pend_valid_r && instr_valid_i && (pend_cnt_r != 2'h0)) begin
			pend_cnt_r <= pend_cnt_r - 2'h1;
		end
	end

	// processor state register, only writable fields change
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			psr_r <= SRWB_PSR_RST;
		end else if (commit_now && (pend_r.tgt == SRWB_TGT_PSR)) begin
			psr_r <= (psr_r & ~SRWB_PSR_WR_MASK) | pend_r.value;
		end
	end

	// window invalid mask, only implemented windows
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wim_r <= SRWB_WIM_RST;
		end else if (commit_now && (pend_r.tgt == SRWB_TGT_WIM)) begin
			wim_r <= (wim_r & ~WIM_WR_MASK) | pend_r.value;
		end
	end

	// trap base register; the trap type field belongs to the trap logic
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tbr_r <= SRWB_TBR_RST;
		end else if (commit_now && (pend_r.tgt == SRWB_TGT_TBR)) begin
			tbr_r <= (tbr_r & ~SRWB_TBR_WR_MASK) | pend_r.value;
		end
	end

	// multiply/divide auxiliary register, written by its own encoding only
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			y_r <= SRWB_Y_RST;
		end else if (commit_now && (pend_r.tgt == SRWB_TGT_Y)) begin
			y_r <= pend_r.value;
		end
	end

	// implementation ancillary registers 16..31
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int k = 0; k < 16; k++) begin
				asr_r[k] <= SRWB_ASR_RST;
			end
		end else if (commit_now && (pend_r.tgt == SRWB_TGT_ASR)) begin
			asr_r[pend_r.asr_idx] <= pend_r.value;
		end
	end

	// trap-enable and level seen by interrupt acceptance follow a write at once;
	// a combined change may still let an old-level interrupt through
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			int_et_r <= SRWB_PSR_RST[SRWB_PSR_ET_BIT];
			int_pil_r <= SRWB_PSR_RST[SRWB_PSR_PIL_LSB +: 4];
		end else if (accept && (tgt == SRWB_TGT_PSR)) begin
			int_et_r <= wval[SRWB_PSR_ET_BIT];
			int_pil_r <= wval[SRWB_PSR_PIL_LSB +: 4];
		end else if (!(pend_valid_r && (pend_r.tgt == SRWB_TGT_PSR))) begin
			int_et_r <= psr_r[SRWB_PSR_ET_BIT];
			int_pil_r <= psr_r[SRWB_PSR_PIL_LSB +: 4];
		end
	end

	// trap report, one cycle after the offending instruction
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			trap_valid_r <= 1'b0;
			trap_code_r <= SRWB_TRAP_NONE;
		end else begin
			trap_valid_r <= priv_viol || (instr_valid_i && is_wr && cwp_bad);
			if (priv_viol) begin
				trap_code_r <= SRWB_TRAP_PRIV;
			end else if (instr_valid_i && is_wr && cwp_bad) begin
				trap_code_r <= SRWB_TRAP_ILLEGAL;
			end
		end
	end

	// outstanding store count
	always_comb begin
		st_out_nxt = st_out_r;
		if (st_issue_i && !st_done_i) begin
			st_out_nxt = st_out_r + ST_CNT_W'(1);
		end else if (st_done_i && !st_issue_i) begin
			st_out_nxt = st_out_r - ST_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_out_r <= '0;
		end else begin
			st_out_r <= st_out_nxt;
		end
	end

	// barrier stalls new store issue until all earlier stores completed
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_hold_r <= 1'b0;
		end else if (barrier && PSO_SUPPORTED && pso_en_r && (st_out_nxt != '0)) begin
			st_hold_r <= 1'b1;
		end else if (st_out_nxt == '0) begin
			st_hold_r <= 1'b0;
		end
	end

	// bus: request answered on the second edge, read data registered at the first
	assign req = avs_read_i || avs_write_i;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !(req && wait_r);
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read_i && wait_r) begin
			case (avs_address_i)
				SRWB_OFS_CTRL: rdata_r <= {31'h0, pso_en_r};
				SRWB_OFS_STATUS: rdata_r <= {16'h0, 4'(st_out_r), 1'b0, pend_r.tgt,
					1'b0, pend_cnt_r, trap_code_r, st_hold_r, pend_valid_r};
				SRWB_OFS_PSR: rdata_r <= psr_r;
				SRWB_OFS_WIM: rdata_r <= wim_r;
				SRWB_OFS_TBR: rdata_r <= tbr_r;
				SRWB_OFS_Y: rdata_r <= y_r;
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// control register; partial store order mode switch
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pso_en_r <= SRWB_CTRL_PSO_RST;
		end else if (avs_write_i && !wait_r && (avs_address_i == SRWB_OFS_CTRL)
			&& avs_byteenable_i[0]) begin
			pso_en_r <= avs_writedata_i[SRWB_CTRL_PSO_BIT];
		end
	end

	// outputs
	assign trap_valid_o = trap_valid_r;
	assign trap_code_o = trap_code_r;
	assign psr_o = psr_r; // committed value only
	assign wim_o = wim_r;
	assign tbr_o = tbr_r;
	assign y_o = y_r;
	assign int_et_o = int_et_r;
	assign int_pil_o = int_pil_r;
	assign st_hold_o = st_hold_r;
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;

endmodule

// >>> include/srwb_pkg.sv
// srwb_pkg: constants, field positions and carrier types for the state register
// write and store barrier unit.
// assumes a 32-bit integer unit with three-operand arithmetic instruction format.
package srwb_pkg;

	// instruction format
	localparam logic [1:0] SRWB_OP_ARITH = 2'h2;
	localparam logic [5:0] SRWB_OP3_WR_AUX = 6'h30;
	localparam logic [5:0] SRWB_OP3_WR_PSR = 6'h31;
	localparam logic [5:0] SRWB_OP3_WR_WIM = 6'h32;
	localparam logic [5:0] SRWB_OP3_WR_TBR = 6'h33;
	localparam logic [5:0] SRWB_OP3_RD_ANC = 6'h28;
	localparam logic [4:0] SRWB_BARRIER_SRC1 = 5'h0f;
	localparam logic [4:0] SRWB_ASR_IMPL_FIRST = 5'h10;
	localparam logic [4:0] SRWB_ASR_PRIV_FIRST = 5'h18;

	// state register fields, write masks and reset values
	localparam int SRWB_PSR_CWP_LSB = 0;
	localparam int SRWB_PSR_ET_BIT = 5;
	localparam int SRWB_PSR_S_BIT = 7;
	localparam int SRWB_PSR_PIL_LSB = 8;
	localparam logic [31:0] SRWB_PSR_WR_MASK = 32'h00f0_0fff;
	localparam logic [31:0] SRWB_PSR_RST = 32'h0000_0080;
	localparam logic [31:0] SRWB_TBR_WR_MASK = 32'hffff_f000;
	localparam logic [31:0] SRWB_TBR_RST = 32'h0000_0000;
	localparam logic [31:0] SRWB_WIM_RST = 32'h0000_0000;
	localparam logic [31:0] SRWB_Y_RST = 32'h0000_0000;
	localparam logic [31:0] SRWB_ASR_RST = 32'h0000_0000;

	// register map, byte addresses
	localparam logic [4:0] SRWB_OFS_CTRL = 5'h00;
	localparam logic [4:0] SRWB_OFS_STATUS = 5'h04;
	localparam logic [4:0] SRWB_OFS_PSR = 5'h08;
	localparam logic [4:0] SRWB_OFS_WIM = 5'h0c;
	localparam logic [4:0] SRWB_OFS_TBR = 5'h10;
	localparam logic [4:0] SRWB_OFS_Y = 5'h14;
	localparam int SRWB_CTRL_PSO_BIT = 0;
	localparam logic SRWB_CTRL_PSO_RST = 1'b0;

	// timing, counted in following instructions
	localparam int SRWB_WR_DELAY = 3;

	typedef enum logic [2:0] {
		SRWB_TGT_Y = 3'h0,
		SRWB_TGT_PSR = 3'h1,
		SRWB_TGT_WIM = 3'h2,
		SRWB_TGT_TBR = 3'h3,
		SRWB_TGT_ASR = 3'h4,
		SRWB_TGT_NONE = 3'h7
	} srwb_tgt_type;

	typedef enum logic [2:0] {
		SRWB_TRAP_NONE = 3'b001,
		SRWB_TRAP_ILLEGAL = 3'b010,
		SRWB_TRAP_PRIV = 3'b100
	} srwb_trap_type;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] rd;
		logic [5:0] op3;
		logic [4:0] rs1;
		logic imm_sel;
		logic [12:0] signed_imm_field;
	} srwb_instr_type;

	typedef struct packed {
		srwb_tgt_type tgt;
		logic [3:0] asr_idx;
		logic [31:0] value;
	} srwb_pend_type;

endpackage

// >>> tb/srwb_core_assertions.sv
// srwb_core_assertions: timing checks on the ports of srwb_core.
// assumes it is bound to every srwb_core instance.
`timescale 1ns/100ps
module srwb_chk import srwb_pkg::*; #(
	parameter int WINDOW_COUNT = 8
) (
	// watched ports
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] src1_val_i,
	input wire logic [31:0] src2_val_i,
	input wire logic trap_take_i,
	input wire logic trap_valid_o,
	input wire srwb_trap_type trap_code_o,
	input wire logic [31:0] psr_o,
	input wire logic int_et_o,
	input wire logic [3:0] int_pil_o,
	input wire logic st_issue_i,
	input wire logic st_done_i,
	input wire logic st_hold_o
);
	srwb_instr_type ins;
	logic [31:0] wv;
	logic wr, wp, ok, bar;
	logic [7:0] out_r;
	// decode of the completing instruction
	assign ins = instr_i;
	assign wv = src1_val_i ^ (ins.imm_sel ? 32'(signed'(ins.signed_imm_field)) : src2_val_i);
	assign wr = instr_valid_i && ins.op == SRWB_OP_ARITH && ins.op3[5:2] == 4'hc;
	assign wp = wr && ins.op3 == SRWB_OP3_WR_PSR && psr_o[SRWB_PSR_S_BIT];
	assign ok = int'(wv[4:0]) < WINDOW_COUNT;
	assign bar = instr_valid_i && ins.op == SRWB_OP_ARITH && ins.op3 == SRWB_OP3_RD_ANC
		&& ins.rs1 == SRWB_BARRIER_SRC1 && ins.rd == 5'h00;
	// stores issued and not yet done
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_r <= 8'h00;
		end else begin
			out_r <= out_r + 8'(st_issue_i) - 8'(st_done_i);
		end
	end
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	chk_user_priv: assert property (wr && !psr_o[SRWB_PSR_S_BIT] &&
		(ins.op3 != SRWB_OP3_WR_AUX || ins.rd >= 5'h18) |=> trap_valid_o &&
		trap_code_o == SRWB_TRAP_PRIV) else $error("user write not refused");
	chk_aux_open: assert property (wr && ins.op3 == SRWB_OP3_WR_AUX && ins.rd < 5'h18
		|=> !trap_valid_o) else $error("open write refused");
	chk_bad_window: assert property (wp && !ok |=> trap_valid_o &&
		trap_code_o == SRWB_TRAP_ILLEGAL) else $error("bad window not refused");
	chk_cwp_range: assert property (int'(psr_o[4:0]) < WINDOW_COUNT)
		else $error("window pointer out of range");
	chk_irq_forward: assert property (wp && ok |=> int_et_o == $past(wv[5]) &&
		int_pil_o == $past(wv[11:8])) else $error("interrupt controls late");
	chk_commit_late: assert property (wp && ok ##1
		(instr_valid_i && !wr && !trap_take_i) [*3] |=> psr_o == ($past(wv, 4) & SRWB_PSR_WR_MASK))
		else $error("write not committed");
	chk_ro_fields: assert property ((psr_o & ~SRWB_PSR_WR_MASK) == 32'h0)
		else $error("read-only field changed");
	chk_hold_cause: assert property ($rose(st_hold_o) |-> $past(bar))
		else $error("hold without barrier");
	chk_hold_drain: assert property (st_hold_o |-> out_r != 8'h00)
		else $error("hold with nothing outstanding");
	cov_priv: cover property (trap_valid_o && trap_code_o == SRWB_TRAP_PRIV);
	cov_bad: cover property (trap_valid_o && trap_code_o == SRWB_TRAP_ILLEGAL);
	cov_drain: cover property ($fell(st_hold_o));
endmodule

bind srwb_core srwb_chk #(.WINDOW_COUNT(WINDOW_COUNT)) i_chk (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .src1_val_i(src1_val_i),
	.src2_val_i(src2_val_i), .trap_take_i(trap_take_i), .trap_valid_o(trap_valid_o),
	.trap_code_o(trap_code_o), .psr_o(psr_o), .int_et_o(int_et_o), .int_pil_o(int_pil_o),
	.st_issue_i(st_issue_i), .st_done_i(st_done_i), .st_hold_o(st_hold_o));

// >>> tb/srwb_core_tb.sv
// srwb_core_tb: self-checking bench for the state register write and barrier unit.
// assumes the store model as far side and one 25 MHz clock.
`timescale 1ns/100ps
module srwb_core_tb import srwb_pkg::*;;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic trap_take_i = 1'b0;
	logic req = 1'b0;
	logic [3:0] lat = 4'hf;
	srwb_instr_type ins = '0;
	logic [31:0] src1_val_i = 32'h0;
	logic [31:0] src2_val_i = 32'h0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] psr_o, wim_o, tbr_o, y_o, avs_readdata_o, a, b, v, p, rd_v;
	logic [3:0] int_pil_o, pil_s;
	logic trap_valid_o, int_et_o, st_issue_i, st_done_i, st_hold_o;
	logic avs_waitrequest_o, tv_s, et_s, i;
	srwb_trap_type trap_code_o, tc_s;
	logic [31:0] msk [4] = '{32'hffffffff, SRWB_PSR_WR_MASK, 32'h000000ff, SRWB_TBR_WR_MASK};
	logic [31:0] regs [4];
	int n_errors = 0;
	int total_checks = 0;
	// registers indexed like the write targets
	assign regs = '{y_o, psr_o, wim_o, tbr_o};
	// clock, 40 ns period
	always #20 core_clk_i = ~core_clk_i;
	srwb_core i_dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(ins),
		.src1_val_i(src1_val_i), .src2_val_i(src2_val_i), .trap_take_i(trap_take_i),
		.trap_valid_o(trap_valid_o), .trap_code_o(trap_code_o), .psr_o(psr_o), .wim_o(wim_o),
		.tbr_o(tbr_o), .y_o(y_o), .int_et_o(int_et_o), .int_pil_o(int_pil_o),
		.st_issue_i(st_issue_i), .st_done_i(st_done_i), .st_hold_o(st_hold_o),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o)
	);
	srwb_store_model i_mem (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .lat_i(lat), .hold_i(st_hold_o),
		.issue_o(st_issue_i), .done_o(st_done_i)
	);
	// value compare
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// verdict and end of run
	task automatic conclude();
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// operand combination expected of every write
	function automatic logic [31:0] xv(logic [31:0] x, logic [31:0] y, logic im);
		return x ^ (im ? 32'(signed'(y[12:0])) : y);
	endfunction
	// one instruction then n fillers; trap and interrupt controls sampled after it
	task automatic ex(logic [5:0] o3, logic [4:0] rd, logic [4:0] rs1, logic [31:0] x,
		logic [31:0] y, logic im, int n);
		@(posedge core_clk_i);
		instr_valid_i <= 1'b1;
		ins <= '{SRWB_OP_ARITH, rd, o3, rs1, im, y[12:0]};
		src1_val_i <= x;
		src2_val_i <= im ? ~y : y;
		@(posedge core_clk_i);
		instr_valid_i <= n > 0;
		ins <= '0;
		#1;
		tv_s = trap_valid_o;
		tc_s = trap_code_o;
		et_s = int_et_o;
		pil_s = int_pil_o;
		repeat (n) @(posedge core_clk_i);
		if (n > 0)
			instr_valid_i <= 1'b0;
		#1;
	endtask
	// one avalon transfer held until waitrequest is seen low
	task automatic bus(logic w, logic [4:0] ad, logic [31:0] d);
		int k = 0;
		@(posedge core_clk_i);
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= ad;
		avs_writedata_i <= d;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 50);
		rd_v = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	// cut a hang short
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_errors++;
		conclude();
	end
	// main sequence
	initial begin
		void'($urandom(32'h3c7660e1));
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		chk("psr", SRWB_PSR_RST, psr_o);
		// random writes to the Y, PSR, WIM and TBR targets, register and immediate operands
		for (int t = 0; t < 12; t++) begin
			a = $urandom;
			b = $urandom;
			i = t[2];
			if (t % 4 == 1) begin
				b = a ^ ($urandom & 32'hffffff60) ^ 32'h80 ^ 32'(t % 8);
				i = 1'b0;
			end
			v = xv(a, b, i);
			ex(SRWB_OP3_WR_AUX + 6'(t % 4), 5'h00, 5'h03, a, b, i, 3);
			chk("trap", 32'h0, 32'(tv_s));
			chk("sreg", v & msk[t % 4], regs[t % 4]);
			if (t % 4 == 1)
				chk("irq", {27'h0, v[11:8], v[5]}, {27'h0, pil_s, et_s});
		end
		// window pointer beyond the implemented windows
		for (int c = 8; c < 32; c += 23) begin
			p = psr_o;
			a = $urandom;
			ex(SRWB_OP3_WR_PSR, 5'h00, 5'h03, a, a ^ 32'h80 ^ 32'(c), 1'b0, 3);
			chk("trap", 32'h1, 32'(tv_s));
			chk("code", 32'(SRWB_TRAP_ILLEGAL), 32'(tc_s));
			chk("psr", p, psr_o);
		end
		// identical write back to back, then a pending write committed by a trap
		a = $urandom;
		ex(SRWB_OP3_WR_PSR, 5'h00, 5'h00, a, a ^ 32'h00f00a82, 1'b0, 0);
		ex(SRWB_OP3_WR_PSR, 5'h00, 5'h00, a, a ^ 32'h00f00a82, 1'b0, 3);
		chk("psr", 32'h00f00a82, psr_o);
		ex(SRWB_OP3_WR_PSR, 5'h00, 5'h00, a, a ^ 32'h00000084, 1'b0, 0);
		@(posedge core_clk_i);
		trap_take_i <= 1'b1;
		@(posedge core_clk_i);
		trap_take_i <= 1'b0;
		#1;
		chk("psr", 32'h00000084, psr_o);
		// level changed with traps off, then traps enabled at the same level
		ex(SRWB_OP3_WR_PSR, 5'h00, 5'h00, a, a ^ 32'h00000f80, 1'b0, 3);
		chk("irq", 32'h1e, {27'h0, pil_s, et_s});
		ex(SRWB_OP3_WR_PSR, 5'h00, 5'h00, a, a ^ 32'h00000fa0, 1'b0, 3);
		chk("irq", 32'h1f, {27'h0, pil_s, et_s});
		chk("psr", 32'h00000fa0, psr_o);
		// ancillary writes leave the aux register alone
		p = y_o;
		for (int r = 5; r < 32; r += 11) begin
			ex(SRWB_OP3_WR_AUX, 5'(r), 5'h01, $urandom, $urandom, 1'b0, 3);
			chk("trap", 32'h0, 32'(tv_s));
			chk("y", p, y_o);
		end
		// user mode: only aux and open ancillary writes pass
		ex(SRWB_OP3_WR_PSR, 5'h00, 5'h00, 32'h0, 32'h0, 1'b0, 3);
		p = wim_o;
		for (int k = 0; k < 6; k++) begin
			ex(SRWB_OP3_WR_AUX + 6'(k < 3 ? 0 : k - 2), k == 1 ? 5'h10 : k == 2 ? 5'h18 : 5'h00,
				5'h01, $urandom, 32'h1, 1'b0, 3);
			chk("trap", 32'(k > 1), 32'(tv_s));
			if (k > 1)
				chk("code", 32'(SRWB_TRAP_PRIV), 32'(tc_s));
		end
		chk("wim", p, wim_o);
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		// barrier: no effect with mode off or other encoding, holds stores with mode on
		bus(1'b0, 5'h18, 32'h0);
		chk("unmapped", 32'h0, rd_v);
		req <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		req <= 1'b0;
		ex(SRWB_OP3_RD_ANC, 5'h00, SRWB_BARRIER_SRC1, 32'h0, 32'h0, 1'b0, 0);
		chk("hold", 32'h0, 32'(st_hold_o));
		bus(1'b1, SRWB_OFS_CTRL, 32'h1);
		bus(1'b0, SRWB_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h1, rd_v);
		ex(SRWB_OP3_RD_ANC, 5'h01, SRWB_BARRIER_SRC1, 32'h0, 32'h0, 1'b0, 0);
		chk("hold", 32'h0, 32'(st_hold_o));
		ex(SRWB_OP3_RD_ANC, 5'h00, SRWB_BARRIER_SRC1, 32'h0, 32'h0, 1'b0, 0);
		chk("hold", 32'h1, 32'(st_hold_o));
		@(posedge core_clk_i);
		req <= 1'b1;
		@(posedge core_clk_i);
		req <= 1'b0;
		for (int w = 0; w < 60 && st_hold_o === 1'b1; w++) @(posedge core_clk_i);
		#1;
		chk("hold", 32'h0, 32'(st_hold_o));
		conclude();
	end
endmodule

// >>> tb/srwb_store_model.sv
// srwb_store_model: store path on the far side of the barrier logic.
// assumes the bench queues stores and sets the memory latency in cycles.
`timescale 1ns/100ps
module srwb_store_model (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic req_i,
	input wire logic [3:0] lat_i,
	// store path
	input wire logic hold_i,
	output logic issue_o,
	output logic done_o
);
	logic [3:0] queue_r;
	logic [3:0] out_r;
	logic [3:0] tmr_r;
	// issue only while not held, memory finishes one store per latency span
	assign issue_o = queue_r != 4'h0 && !hold_i;
	assign done_o = out_r != 4'h0 && tmr_r >= lat_i;
	// queue, outstanding count and latency timer
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			queue_r <= 4'h0;
			out_r <= 4'h0;
			tmr_r <= 4'h0;
		end else begin
			queue_r <= queue_r + 4'(req_i) - 4'(issue_o);
			out_r <= out_r + 4'(issue_o) - 4'(done_o);
			tmr_r <= (done_o || out_r == 4'h0) ? 4'h0 : tmr_r + 4'h1;
		end
	end
endmodule
